/* include/phy_vendor_regs.svh */
// Offsets, field positions, reset values and timing of the vendor registers
`ifndef PHY_VENDOR_REGS_SVH
`define PHY_VENDOR_REGS_SVH

`define REG_IRQ       5'h10
`define REG_STAT      5'h11
`define REG_CTRL      5'h12

`define EV_ACK        0
`define EV_PAGE       1
`define EV_LINK       2
`define EV_AN         3
`define EV_PDF        4
`define EV_RMT        5
`define EV_JAB        6
`define IRQ_EN_LSB    8

`define ST_LINK       14
`define ST_DUPLEX     13
`define ST_SPEED      12
`define ST_DONE       10
`define ST_PAGE       9
`define ST_NOCOMMON   8
`define ST_POL        5

`define CT_FAR        14
`define CT_MIILB      13
`define CT_LTEST      12
`define CT_POLFIX     11
`define CT_JABEN      10
`define CT_UNALIGN    7
`define CT_CODER      6
`define CT_SCRAM      5
`define CT_DISC       4
`define CT_TEST       3
`define CTRL_MASK     16'h7CF8
`define CTRL_RESET    16'h2400
`define IRQ_EN_RESET  7'h00

`define PREAMBLE_LEN  6'h20
`define CLK_NS        50
`define STARTUP_NS    1000
`define STARTUP_CYC   ((`STARTUP_NS + `CLK_NS - 1) / `CLK_NS)

`endif

/* include/phy_vendor_pkg.sv */
// Types shared by the vendor register block
package phy_vendor_pkg;

  typedef struct packed {
    logic       transceiver_on;
    logic       autoneg_off;
    logic       speed100_off;
    logic       speed10_off;
    logic [4:0] mgmt_phy_addr;
  } startup_ctrl_t;

  typedef struct packed {
    logic std_link_state;
    logic std_autoneg_done;
    logic lp_ack;
    logic page_rx_state;
    logic no_common_mode;
    logic remote_fault;
    logic std_jabber_detect;
    logic pardet_fault;
    logic autoneg_change;
    logic full_duplex_state;
    logic speed_100_state;
    logic rx_polarity_reversed;
    logic analog_loopback;
    logic std_an_enable;
    logic std_speed_sel;
    logic std_full_duplex;
  } core_status_t;

  typedef struct packed {
    logic mii_loopback_en;
    logic far_fault_en;
    logic jabber_detect_en;
    logic link_test_en;
    logic polarity_fix_en;
    logic coder_bypass;
    logic scrambler_bypass;
    logic symbol_unaligned;
    logic line_hiz;
    logic force_txrx;
    logic analog_power;
    logic autoneg_en;
    logic speed100_en;
    logic speed10_en;
  } line_cfg_t;

  typedef enum logic [2:0] {
    MODE_OFF, MODE_AN, MODE_10_HALF, MODE_10_FULL,
    MODE_100_HALF, MODE_100_FULL
  } op_mode_t;

  typedef enum logic [2:0] {
    MS_PRE, MS_ST, MS_OP, MS_ADDR, MS_TA, MS_DATA
  } mdio_state_t;

endpackage

/* src/pin_sync.sv */
// Two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_reg;

  if (WIDTH < 1) begin : g_chk
    $error("pin_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= '0;
      q_o      <= '0;
    end else begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end
endmodule

/* src/phy_vendor_regs_and_startup.sv */
// Vendor register bank, MDIO slave and start-up sequencing of the transceiver
`timescale 1ns/1ps
`include "phy_vendor_regs.svh"
module phy_vendor_regs_and_startup #(
  parameter int unsigned STARTUP_CYCLES = `STARTUP_CYC
) (
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  mdc_i,
  input  wire logic                  mdio_i,
  input  phy_vendor_pkg::startup_ctrl_t startup_i,
  input  phy_vendor_pkg::core_status_t  status_i,
  output logic                       mdio_o,
  output logic                       mdio_oe_o,
  output logic                       irq_o,
  output logic                       mgmt_ready_o,
  output phy_vendor_pkg::line_cfg_t  cfg_o,
  output phy_vendor_pkg::op_mode_t   op_mode_o
);
  import phy_vendor_pkg::*;

  if (STARTUP_CYCLES < 1 || STARTUP_CYCLES > 65535) begin : g_chk
    $error("STARTUP_CYCLES must lie in 1..65535");
  end

  // ***********************************************************
  // Pin sampling
  // ***********************************************************
  logic [1:0]  pins_s;
  logic        mdc_prev_reg;
  logic        mdc_rise;
  logic        mdio_bit;

  pin_sync #(
    .WIDTH (2)
  ) u_pin_sync (
    .clk_i   (ref_clk_i),
    .rst_n_i (rst_n_i),
    .d_i     ({mdc_i, mdio_i}),
    .q_o     (pins_s)
  );

  assign mdc_rise = pins_s[1] & ~mdc_prev_reg;
  assign mdio_bit = pins_s[0];

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mdc_prev_reg <= 1'b0;
    end else begin
      mdc_prev_reg <= pins_s[1];
    end
  end

  // ***********************************************************
  // Start-up delay
  // ***********************************************************
  logic        on_prev_reg;
  logic [15:0] start_cnt_reg;
  logic        ready_reg;
  logic        xcvr_on;

  assign xcvr_on = startup_i.transceiver_on;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      on_prev_reg   <= 1'b0;
      start_cnt_reg <= 16'h0000;
      ready_reg     <= 1'b0;
    end else begin
      on_prev_reg <= xcvr_on;
      if (!xcvr_on) begin
        start_cnt_reg <= 16'h0000;
        ready_reg     <= 1'b0;
      end else if (!on_prev_reg) begin
        start_cnt_reg <= 16'(STARTUP_CYCLES - 1);
        ready_reg     <= 1'b0;
      end else if (start_cnt_reg != 16'h0000) begin
        start_cnt_reg <= start_cnt_reg - 16'h0001;
      end else begin
        ready_reg <= 1'b1;
      end
    end
  end

  assign mgmt_ready_o = ready_reg;

  // ***********************************************************
  // Management frame engine
  // ***********************************************************
  mdio_state_t mstate_reg;
  logic [5:0]  bit_cnt_reg;
  logic [15:0] shift_reg;
  logic [15:0] dout_reg;
  logic        op_read_reg;
  logic        hit_reg;
  logic [4:0]  regad_reg;
  logic        rd_acc_reg;
  logic        wr_stb_reg;
  logic [15:0] wr_data_reg;
  logic [15:0] rd_word;
  logic [9:0]  addr_in;

  assign addr_in = {shift_reg[8:0], mdio_bit};

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mstate_reg  <= MS_PRE;
      bit_cnt_reg <= 6'h00;
      shift_reg   <= 16'h0000;
      dout_reg    <= 16'h0000;
      op_read_reg <= 1'b0;
      hit_reg     <= 1'b0;
      regad_reg   <= 5'h00;
      rd_acc_reg  <= 1'b0;
      wr_stb_reg  <= 1'b0;
      wr_data_reg <= 16'h0000;
      mdio_o      <= 1'b0;
      mdio_oe_o   <= 1'b0;
    end else begin
      rd_acc_reg <= 1'b0;
      wr_stb_reg <= 1'b0;
      if (!ready_reg) begin
        mstate_reg  <= MS_PRE;
        bit_cnt_reg <= 6'h00;
        mdio_oe_o   <= 1'b0;
        mdio_o      <= 1'b0;
      end else if (mdc_rise) begin
        case (mstate_reg)
          MS_PRE: begin
            if (mdio_bit) begin
              if (bit_cnt_reg != `PREAMBLE_LEN) begin
                bit_cnt_reg <= bit_cnt_reg + 6'h01;
              end
            end else if (bit_cnt_reg == `PREAMBLE_LEN) begin
              mstate_reg  <= MS_ST;
              bit_cnt_reg <= 6'h00;
            end else begin
              bit_cnt_reg <= 6'h00;
            end
          end
          MS_ST: begin
            mstate_reg  <= mdio_bit ? MS_OP : MS_PRE;
            bit_cnt_reg <= 6'h00;
          end
          MS_OP: begin
            shift_reg   <= {shift_reg[14:0], mdio_bit};
            bit_cnt_reg <= bit_cnt_reg + 6'h01;
            if (bit_cnt_reg == 6'h01) begin
              bit_cnt_reg <= 6'h00;
              if (shift_reg[0] != mdio_bit) begin
                op_read_reg <= shift_reg[0];
                mstate_reg  <= MS_ADDR;
              end else begin
                mstate_reg <= MS_PRE;
              end
            end
          end
          MS_ADDR: begin
            shift_reg   <= {shift_reg[14:0], mdio_bit};
            bit_cnt_reg <= bit_cnt_reg + 6'h01;
            if (bit_cnt_reg == 6'h09) begin
              bit_cnt_reg <= 6'h00;
              mstate_reg  <= MS_TA;
              regad_reg   <= addr_in[4:0];
              hit_reg     <= addr_in[9:5] ==
                             startup_i.mgmt_phy_addr;
              if (op_read_reg &&
                  addr_in[9:5] == startup_i.mgmt_phy_addr) begin
                dout_reg   <= rd_word;
                rd_acc_reg <= addr_in[4:0] == `REG_IRQ;
              end
            end
          end
          MS_TA: begin
            bit_cnt_reg <= bit_cnt_reg + 6'h01;
            if (op_read_reg && hit_reg) begin
              mdio_oe_o <= 1'b1;
              if (bit_cnt_reg == 6'h00) begin
                mdio_o <= 1'b0;
              end else begin
                mdio_o   <= dout_reg[15];
                dout_reg <= {dout_reg[14:0], 1'b0};
              end
            end
            if (bit_cnt_reg == 6'h01) begin
              bit_cnt_reg <= 6'h00;
              mstate_reg  <= MS_DATA;
            end
          end
          MS_DATA: begin
            shift_reg   <= {shift_reg[14:0], mdio_bit};
            bit_cnt_reg <= bit_cnt_reg + 6'h01;
            if (op_read_reg && hit_reg) begin
              mdio_o   <= dout_reg[15];
              dout_reg <= {dout_reg[14:0], 1'b0};
            end
            if (bit_cnt_reg == 6'h0F) begin
              bit_cnt_reg <= 6'h00;
              mstate_reg  <= MS_PRE;
              mdio_oe_o   <= 1'b0;
              mdio_o      <= 1'b0;
              if (!op_read_reg && hit_reg) begin
                wr_stb_reg  <= 1'b1;
                wr_data_reg <= {shift_reg[14:0], mdio_bit};
              end
            end
          end
          default: begin
            mstate_reg <= MS_PRE;
          end
        endcase
      end
    end
  end

  // ***********************************************************
  // Event detection
  // ***********************************************************
  logic [6:0]  lvl_prev_reg;
  logic [6:0]  lvl_now;
  logic [6:0]  ev_set;
  logic        link_down;

  assign link_down = ~status_i.std_link_state;

  assign lvl_now = {status_i.std_jabber_detect,
                    status_i.remote_fault,
                    status_i.pardet_fault,
                    1'b0,
                    link_down,
                    status_i.page_rx_state,
                    status_i.lp_ack};

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lvl_prev_reg <= 7'h00;
    end else begin
      lvl_prev_reg <= lvl_now;
    end
  end

  always_comb begin
    ev_set = lvl_now & ~lvl_prev_reg;
    ev_set[`EV_ACK]  = status_i.lp_ack &
                       ~lvl_prev_reg[`EV_ACK];
    ev_set[`EV_PDF]  = status_i.pardet_fault &
                       ~lvl_prev_reg[`EV_PDF];
    ev_set[`EV_RMT]  = status_i.remote_fault &
                       ~lvl_prev_reg[`EV_RMT];
    ev_set[`EV_JAB]  = status_i.std_jabber_detect &
                       ~lvl_prev_reg[`EV_JAB];
    ev_set[`EV_LINK] = link_down ^ lvl_prev_reg[`EV_LINK];
    ev_set[`EV_AN]   = status_i.autoneg_change;
  end

  // ***********************************************************
  // Register file
  // ***********************************************************
  logic [6:0]  flag_reg;
  logic [6:0]  irq_en_reg;
  logic [15:0] ctrl_reg;
  logic        irq_acc;

  assign irq_acc = rd_acc_reg |
                   (wr_stb_reg && regad_reg == `REG_IRQ);

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_reg <= 7'h00;
    end else if (!xcvr_on) begin
      flag_reg <= 7'h00;
    end else begin
      flag_reg <= (flag_reg & ~{7{irq_acc}}) | ev_set;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_en_reg <= `IRQ_EN_RESET;
      ctrl_reg   <= `CTRL_RESET;
    end else if (!xcvr_on) begin
      irq_en_reg <= `IRQ_EN_RESET;
      ctrl_reg   <= `CTRL_RESET;
    end else if (wr_stb_reg) begin
      if (regad_reg == `REG_IRQ) begin
        irq_en_reg <= wr_data_reg[`IRQ_EN_LSB +: 7];
      end else if (regad_reg == `REG_CTRL) begin
        ctrl_reg <= wr_data_reg & `CTRL_MASK;
      end
    end
  end

  always_comb begin
    rd_word = 16'h0000;
    if (addr_in[4:0] == `REG_IRQ) begin
      rd_word = {1'b0, irq_en_reg, 1'b0, flag_reg};
    end else if (addr_in[4:0] == `REG_STAT) begin
      rd_word[`ST_LINK]     = link_down;
      rd_word[`ST_DUPLEX]   = status_i.full_duplex_state;
      rd_word[`ST_SPEED]    = status_i.speed_100_state;
      rd_word[`ST_DONE]     = status_i.std_autoneg_done;
      rd_word[`ST_PAGE]     = status_i.page_rx_state;
      rd_word[`ST_NOCOMMON] = status_i.no_common_mode &
                              status_i.std_autoneg_done;
      rd_word[`ST_POL]      = status_i.rx_polarity_reversed;
    end else if (addr_in[4:0] == `REG_CTRL) begin
      rd_word = ctrl_reg;
    end
  end

  // ***********************************************************
  // Operating configuration
  // ***********************************************************
  logic        an_active;
  logic        is_100_full;
  op_mode_t    mode_next;

  assign an_active = status_i.std_an_enable &
                     ~startup_i.autoneg_off;

  always_comb begin
    if (!xcvr_on) begin
      mode_next = MODE_OFF;
    end else if (an_active) begin
      mode_next = MODE_AN;
    end else if (status_i.std_speed_sel) begin
      mode_next = status_i.std_full_duplex ? MODE_100_FULL
                                           : MODE_100_HALF;
    end else begin
      mode_next = status_i.std_full_duplex ? MODE_10_FULL
                                           : MODE_10_HALF;
    end
  end

  assign is_100_full = mode_next == MODE_100_FULL;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_o     <= '0;
      op_mode_o <= MODE_OFF;
      irq_o     <= 1'b0;
    end else begin
      op_mode_o <= mode_next;
      irq_o     <= |(flag_reg & irq_en_reg);
      cfg_o.analog_power     <= xcvr_on;
      cfg_o.mii_loopback_en  <= xcvr_on &
                                ~ctrl_reg[`CT_MIILB];
      cfg_o.far_fault_en     <= xcvr_on & ~an_active &
                                ~ctrl_reg[`CT_FAR];
      cfg_o.jabber_detect_en <= ctrl_reg[`CT_JABEN];
      cfg_o.link_test_en     <= ~ctrl_reg[`CT_LTEST];
      cfg_o.polarity_fix_en  <= ~ctrl_reg[`CT_POLFIX];
      cfg_o.coder_bypass     <= is_100_full &
                                ctrl_reg[`CT_CODER];
      cfg_o.scrambler_bypass <= is_100_full &
                                ctrl_reg[`CT_SCRAM];
      cfg_o.symbol_unaligned <= is_100_full &
                                ctrl_reg[`CT_CODER] &
                                ctrl_reg[`CT_UNALIGN];
      cfg_o.line_hiz         <= ~xcvr_on |
                                ctrl_reg[`CT_DISC] |
                                status_i.analog_loopback;
      cfg_o.force_txrx       <= xcvr_on &
                                ctrl_reg[`CT_TEST];
      cfg_o.autoneg_en       <= xcvr_on &
                                ~startup_i.autoneg_off;
      cfg_o.speed100_en      <= xcvr_on &
                                ~startup_i.speed100_off;
      cfg_o.speed10_en       <= xcvr_on &
                                ~startup_i.speed10_off;
    end
  end
endmodule

/* bench/phy_vendor_regs_props.sv */
// Port-level checks on the vendor register block
`timescale 1ns/1ps
module phy_vendor_regs_props #(
  parameter int unsigned STARTUP_CYCLES = 20
) (
  input wire logic                          ref_clk_i,
  input wire logic                          rst_n_i,
  input wire phy_vendor_pkg::startup_ctrl_t startup_i,
  input wire phy_vendor_pkg::core_status_t  status_i,
  input wire logic                          mdio_oe_o,
  input wire logic                          mgmt_ready_o,
  input wire phy_vendor_pkg::line_cfg_t     cfg_o,
  input wire phy_vendor_pkg::op_mode_t      op_mode_o
);
  import phy_vendor_pkg::*;
  logic [7:0] on_cnt;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ****************
  // Enabled time
  // ****************
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) on_cnt <= 8'h00;
    else if (!startup_i.transceiver_on) on_cnt <= 8'h00;
    else if (on_cnt != 8'hFF) on_cnt <= on_cnt + 8'h01;
  end
  function automatic op_mode_t exp_mode(logic s, logic d);
    if (s) return d ? MODE_100_FULL : MODE_100_HALF;
    return d ? MODE_10_FULL : MODE_10_HALF;
  endfunction
  // Reset level in the sample keeps the release edge out of the check
  sequence s_off;
    !startup_i.transceiver_on && rst_n_i;
  endsequence
  sequence s_quiet;
    cfg_o.line_hiz && !cfg_o.analog_power && !mdio_oe_o;
  endsequence
  sequence s_manual;
    mgmt_ready_o && startup_i.transceiver_on && !status_i.std_an_enable
      && !startup_i.speed100_off && !startup_i.speed10_off;
  endsequence
  a_off_pins_quiet: assert property (s_off |=> s_quiet)
    else $error("pins not quiet while disabled");
  a_off_mode_idle: assert property (s_off |=> op_mode_o == MODE_OFF)
    else $error("mode set while disabled");
  a_loop_forces_hiz: assert property (
    status_i.analog_loopback |=> cfg_o.line_hiz)
    else $error("analog loopback left line driven");
  a_manual_mode_map: assert property (s_manual |=>
    op_mode_o == exp_mode($past(status_i.std_speed_sel),
                          $past(status_i.std_full_duplex)))
    else $error("manual mode mismatch");
  a_unalign_needs_sym: assert property (
    cfg_o.symbol_unaligned |-> cfg_o.coder_bypass)
    else $error("unaligned outside symbol mode");
  a_bypass_fast_only: assert property (
    cfg_o.coder_bypass || cfg_o.scrambler_bypass |->
    op_mode_o == MODE_100_FULL || $past(op_mode_o) == MODE_100_FULL)
    else $error("bypass outside fast full duplex");
  a_far_fault_gate: assert property (cfg_o.far_fault_en |->
    !$past(status_i.std_an_enable) || $past(startup_i.autoneg_off))
    else $error("far fault on while negotiating");
  a_ready_after_delay: assert property (
    mgmt_ready_o |-> on_cnt >= STARTUP_CYCLES)
    else $error("management ready too early");
endmodule

/* bench/mdio_station.sv */
// Station management model driving frames on the management pins
`timescale 1ns/1ps
module mdio_station (
  output logic     mdc_o,
  output logic     mdio_o,
  output logic     mdio_oe_o,
  input wire logic mdio_i
);
  initial begin
    mdc_o = 1'b0;
    mdio_o = 1'b1;
    mdio_oe_o = 1'b0;
  end
  // Data set while clock low, line sampled on the rise
  task automatic bit_cyc(input logic b, input logic drv, output logic s);
    mdio_oe_o = drv;
    mdio_o = b;
    #200;
    mdc_o = 1'b1;
    s = mdio_i;
    #200;
    mdc_o = 1'b0;
  endtask
  // Clock stands low between frames
  task automatic frame(input logic rd, input logic [4:0] phy,
                       input logic [4:0] ra, input logic [15:0] wd,
                       output logic [15:0] rdat);
    logic [45:0] hdr;
    logic s;
    hdr = {32'hFFFFFFFF, 2'b01, rd ? 2'b10 : 2'b01, phy, ra};
    for (int i = 45; i >= 0; i--) bit_cyc(hdr[i], 1'b1, s);
    for (int i = 1; i >= 0; i--) bit_cyc(i == 1, !rd, s);
    for (int i = 15; i >= 0; i--) begin
      bit_cyc(wd[i], !rd, s);
      rdat[i] = s;
    end
    mdio_oe_o = 1'b0;
  endtask
endmodule

/* bench/phy_vendor_regs_and_startup_bench.sv */
// Register-level test of the vendor register block over management pins
`timescale 1ns/1ps
`include "phy_vendor_regs.svh"
module phy_vendor_regs_and_startup_bench;
  import phy_vendor_pkg::*;
  localparam int unsigned SC = 4;
  localparam logic [4:0] PHY = 5'h05;
  localparam int EVP [7] = '{13, 12, 15, 7, 8, 10, 9};
  localparam op_mode_t MODES [4] = '{MODE_10_HALF, MODE_10_FULL,
                                     MODE_100_HALF, MODE_100_FULL};
  logic          ref_clk_i, rst_n_i, mdc, st_do, st_oe;
  logic          dut_do, dut_oe, line, irq, ready;
  logic [15:0]   rdat;
  startup_ctrl_t startup;
  core_status_t  status;
  line_cfg_t     cfg;
  op_mode_t      mode;
  int            error_cnt = 0;
  int            check_count = 0;
  // Line with pull-up
  assign line = dut_oe ? dut_do : (st_oe ? st_do : 1'b1);
  phy_vendor_regs_and_startup #(.STARTUP_CYCLES(SC)) dut (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .mdc_i(mdc),
    .mdio_i(line), .startup_i(startup), .status_i(status),
    .mdio_o(dut_do), .mdio_oe_o(dut_oe), .irq_o(irq),
    .mgmt_ready_o(ready), .cfg_o(cfg), .op_mode_o(mode));
  mdio_station st (.mdc_o(mdc), .mdio_o(st_do), .mdio_oe_o(st_oe),
    .mdio_i(line));
  // ****************
  // Tasks
  // ****************
  task automatic final_report;
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic rd(input logic [4:0] ra, input logic [15:0] exp);
    st.frame(1'b1, PHY, ra, 16'h0000, rdat);
    check(rdat, exp);
  endtask
  task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
    st.frame(1'b0, PHY, ra, wd, rdat);
    cyc(4);
  endtask
  task automatic wait_ready;
    int n;
    for (n = 0; n < 60 && ready !== 1'b1; n++) begin
      @(posedge ref_clk_i);
      #1;
    end
    if (ready !== 1'b1) begin
      error_cnt++;
      final_report;
    end
    check({15'h0, n >= SC}, 16'h0001);
  endtask
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    repeat (100000) @(posedge ref_clk_i);
    error_cnt++;
    final_report;
  end
  // ****************
  // Sequence
  // ****************
  initial begin
    rst_n_i = 1'b0;
    startup = {1'b0, 1'b1, 1'b0, 1'b0, PHY};
    status = 16'h8000;
    repeat (5) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    cyc(2);
    check({15'h0, cfg.line_hiz}, 16'h0001);
    check({13'h0, cfg[2:0]}, 16'h0000);
    rd(`REG_CTRL, 16'hFFFF);
    @(posedge ref_clk_i) startup.transceiver_on <= 1'b1;
    wait_ready();
    check({13'h0, cfg[2:0]}, 16'h0003);
    rd(`REG_CTRL, 16'h2400);
    rd(`REG_IRQ, 16'h0000);
    rd(5'h13, 16'h0000);
    st.frame(1'b1, 5'h06, `REG_CTRL, 16'h0000, rdat);
    check(rdat, 16'hFFFF);
    wr(`REG_CTRL, 16'hFFFF);
    rd(`REG_CTRL, 16'h7CF8);
    check({5'h0, cfg[13:3]}, 16'h0107);
    wr(`REG_CTRL, 16'h0000);
    check({5'h0, cfg[13:3]}, 16'h06C1);
    @(posedge ref_clk_i) status[3] <= 1'b1;
    cyc(3);
    check({15'h0, cfg.line_hiz}, 16'h0001);
    @(posedge ref_clk_i) status[3] <= 1'b0;
    wr(`REG_CTRL, 16'h24E0);
    for (int m = 0; m < 4; m++) begin
      @(posedge ref_clk_i) status[1:0] <= m[1:0];
      cyc(3);
      check({13'h0, mode}, {13'h0, MODES[m]});
      check({13'h0, cfg[8:6]}, (m == 3) ? 16'h0007 : 16'h0000);
    end
    wr(`REG_IRQ, 16'h7F00);
    rd(`REG_IRQ, 16'h7F00);
    for (int e = 0; e < 7; e++) begin
      @(posedge ref_clk_i) status <= status ^ (16'h1 << EVP[e]);
      if (e == 3) @(posedge ref_clk_i) status <= status ^ 16'h0080;
      cyc(3);
      check({15'h0, irq}, 16'h0001);
      rd(`REG_IRQ, 16'h7F00 | (16'h1 << e));
      rd(`REG_IRQ, 16'h7F00);
      @(posedge ref_clk_i) if (e != 3) status <= status ^ (16'h1 << EVP[e]);
      cyc(3);
      st.frame(1'b1, PHY, `REG_IRQ, 16'h0000, rdat);
      check(rdat, (e == 2) ? 16'h7F04 : 16'h7F00);
    end
    wr(`REG_IRQ, 16'h0000);
    @(posedge ref_clk_i) status[9] <= 1'b1;
    cyc(3);
    check({15'h0, irq}, 16'h0000);
    rd(`REG_IRQ, 16'h0040);
    @(posedge ref_clk_i) status <= 16'h5870;
    cyc(3);
    rd(`REG_STAT, 16'h7720);
    @(posedge ref_clk_i) status <= 16'h8800;
    cyc(3);
    rd(`REG_STAT, 16'h0000);
    @(posedge ref_clk_i) startup.transceiver_on <= 1'b0;
    cyc(3);
    check({15'h0, cfg.line_hiz}, 16'h0001);
    @(posedge ref_clk_i) startup.transceiver_on <= 1'b1;
    wait_ready();
    rd(`REG_CTRL, 16'h2400);
    @(posedge ref_clk_i) begin
      startup.autoneg_off <= 1'b0;
      status[2] <= 1'b1;
    end
    cyc(3);
    check({13'h0, mode}, {13'h0, MODE_AN});
    check({13'h0, cfg[2:0]}, 16'h0007);
    check({15'h0, cfg.far_fault_en}, 16'h0000);
    final_report;
  end
endmodule
bind phy_vendor_regs_and_startup phy_vendor_regs_props #(
  .STARTUP_CYCLES(STARTUP_CYCLES)
) u_props (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .startup_i(startup_i),
  .status_i(status_i), .mdio_oe_o(mdio_oe_o),
  .mgmt_ready_o(mgmt_ready_o), .cfg_o(cfg_o), .op_mode_o(op_mode_o)
);
